/* File: hdl/fpdp_top.sv */
// APB register front and data staging of the flash programming controller
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpdp_consts.svh"

module fpdp_top
(
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Flash controller side
    input wire logic flashDone,
    input wire logic flashError,
    input wire logic lowVoltError,
    output logic [3:0] flashOp,
    output logic flashStart,
    output logic [31:0] flashTargetAddr,
    output logic [63:0] flashProgramData,
    output logic [31:0] rowSourceAddr,
    output logic rowFetch
);

    // Register state and its next value
    fpdp_pkg::fpdp_state_t state_q;
    fpdp_pkg::fpdp_state_t state_d;

    // Address decode
    logic [11:0] regBase;        // Address with alias bits dropped
    logic [1:0] aliasKind;       // Which alias the access hits
    logic hitCtrl;
    logic hitTarget;
    logic hitLo;
    logic hitHi;
    logic hitSrc;
    logic mapped;
    logic setupPhase;            // First cycle of an APB transfer
    logic accessWrite;           // Write taking effect this edge
    logic [31:0] laneMask;       // Byte enables spread to bits
    logic [31:0] ctrlView;       // Control register as read
    logic [31:0] selOld;         // Old value of the addressed register
    logic [31:0] mergedVal;      // Value after alias merge
    logic wrRise;                // Write bit goes from clear to set

    assign regBase = {paddr[11:4], 4'h0};
    assign aliasKind = paddr[3:2];
    assign hitCtrl = (regBase == `FPDP_OFF_CTRL);
    assign hitTarget = (regBase == `FPDP_OFF_TARGET);
    assign hitLo = (regBase == `FPDP_OFF_DATA_LO);
    assign hitHi = (regBase == `FPDP_OFF_DATA_HI);
    assign hitSrc = (regBase == `FPDP_OFF_SRCADDR);
    assign mapped = hitCtrl | hitTarget | hitLo | hitHi | hitSrc;
    assign setupPhase = psel & ~penable;
    assign accessWrite = psel & penable & pwrite & mapped;

    // Byte lane mask, one generate step per lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1)
        begin : g_lane
            assign laneMask[lane*8 +: 8] = {8{pstrb[lane]}};
        end
    endgenerate

    // Control register image; unused bits read zero
    always_comb
    begin
        ctrlView = 32'h00000000;
        ctrlView[`FPDP_CTRL_OP_MSB:`FPDP_CTRL_OP_LSB] = state_q.opSel;
        ctrlView[`FPDP_CTRL_WREN] = state_q.wrEnable;
        ctrlView[`FPDP_CTRL_WR] = state_q.wrStart;
        ctrlView[`FPDP_CTRL_WRERR] = state_q.wrError;
        ctrlView[`FPDP_CTRL_LVDERR] = state_q.lvError;
    end

    // Old value of whichever register is addressed
    always_comb
    begin
        if (hitCtrl)
        begin
            selOld = ctrlView;
        end
        else if (hitTarget)
        begin
            selOld = state_q.target;
        end
        else if (hitLo)
        begin
            selOld = state_q.dataLo;
        end
        else if (hitHi)
        begin
            selOld = state_q.dataHi;
        end
        else if (hitSrc)
        begin
            selOld = state_q.srcAddr;
        end
        else
        begin
            selOld = 32'h00000000;
        end
    end

    // Shared merge unit; only one register is written per transfer
    fpdp_alias_merge u_merge
    (
        .oldVal(selOld),
        .wrData(pwdata),
        .laneMask(laneMask),
        .aliasKind(aliasKind),
        .newVal(mergedVal)
    );

    // Next state of every register
    always_comb
    begin
        state_d = state_q;
        state_d.startPulse = 1'b0;
        state_d.rowPulse = 1'b0;
        wrRise = 1'b0;

        // Read data and error are captured in the setup cycle
        if (setupPhase)
        begin
            state_d.rdata = pwrite ? 32'h00000000 : selOld;
            state_d.slvErr = ~mapped;
        end

        // Hardware ends the operation; a software set below wins
        if (flashDone)
        begin
            state_d.wrStart = 1'b0;
        end

        // Software writes, whole register or through an alias
        if (accessWrite)
        begin
            if (hitCtrl)
            begin
                state_d.opSel = mergedVal[`FPDP_CTRL_OP_MSB:`FPDP_CTRL_OP_LSB];
                state_d.wrEnable = mergedVal[`FPDP_CTRL_WREN];
                state_d.wrError = mergedVal[`FPDP_CTRL_WRERR];
                state_d.lvError = mergedVal[`FPDP_CTRL_LVDERR];
                // Start needs write enable, so stray writes cannot program
                if (mergedVal[`FPDP_CTRL_WR] && mergedVal[`FPDP_CTRL_WREN])
                begin
                    state_d.wrStart = 1'b1;
                    wrRise = ~state_q.wrStart;
                end
                else if (!mergedVal[`FPDP_CTRL_WR])
                begin
                    state_d.wrStart = 1'b0;
                end
            end
            if (hitTarget)
            begin
                state_d.target = mergedVal;
            end
            if (hitLo)
            begin
                state_d.dataLo = mergedVal;
            end
            if (hitHi)
            begin
                state_d.dataHi = mergedVal;
            end
            if (hitSrc)
            begin
                state_d.srcAddr = mergedVal;
            end
        end

        // Error flags: a hardware event wins over a software clear
        if (flashError)
        begin
            state_d.wrError = 1'b1;
        end
        if (lowVoltError)
        begin
            state_d.lvError = 1'b1;
        end

        // Launch the selected operation on the rising write bit
        if (wrRise)
        begin
            state_d.startPulse = 1'b1;
            // Row program takes its data from system memory
            if (state_d.opSel == `FPDP_OP_ROW)
            begin
                state_d.rowPulse = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q.opSel <= `FPDP_RST_OP;
            state_q.wrEnable <= 1'b0;
            state_q.wrStart <= 1'b0;
            state_q.wrError <= 1'b0;
            state_q.lvError <= 1'b0;
            state_q.target <= `FPDP_RST_WORD;
            state_q.dataLo <= `FPDP_RST_WORD;
            state_q.dataHi <= `FPDP_RST_WORD;
            state_q.srcAddr <= `FPDP_RST_WORD;
            state_q.rdata <= `FPDP_RST_WORD;
            state_q.slvErr <= 1'b0;
            state_q.startPulse <= 1'b0;
            state_q.rowPulse <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // APB answers in the first access cycle, never waits
    assign pready = 1'b1;
    assign prdata = state_q.rdata;
    assign pslverr = psel & penable & state_q.slvErr;

    // Controller link; holding words pass straight through and change as soon as software rewrites them
    assign flashOp = state_q.opSel;
    assign flashStart = state_q.startPulse;
    assign flashTargetAddr = state_q.target;
    assign flashProgramData = {state_q.dataHi, state_q.dataLo};
    assign rowSourceAddr = state_q.srcAddr;
    assign rowFetch = state_q.rowPulse;

endmodule : fpdp_top

`default_nettype wire

/* File: hdl/fpdp_consts.svh */
// Offsets, field positions, reset values and codes of the flash program data path
// What this block does
// - Double-word program writes high:low to target
// - Low holding word is least significant word
// - Row program fetches from source address register
// - Operation select sits in control bits 3:0
// - Clear, set, invert aliases at +4, +8, +C
// - Data and source registers 32-bit, reset zero
`ifndef FPDP_CONSTS_SVH
`define FPDP_CONSTS_SVH

// Register byte offsets inside the block window
`define FPDP_ADDR_W 12
`define FPDP_OFF_CTRL 12'h380
`define FPDP_OFF_TARGET 12'h3A0
`define FPDP_OFF_DATA_LO 12'h3B0
`define FPDP_OFF_DATA_HI 12'h3C0
`define FPDP_OFF_SRCADDR 12'h3D0

// Alias selector in address bits 3:2
`define FPDP_ALIAS_NONE 2'h0
`define FPDP_ALIAS_CLR 2'h1
`define FPDP_ALIAS_SET 2'h2
`define FPDP_ALIAS_INV 2'h3

// Control register fields
`define FPDP_CTRL_OP_LSB 0
`define FPDP_CTRL_OP_MSB 3
`define FPDP_CTRL_LVDERR 12
`define FPDP_CTRL_WRERR 13
`define FPDP_CTRL_WREN 14
`define FPDP_CTRL_WR 15

// Operation select codes
`define FPDP_OP_DWORD 4'h2
`define FPDP_OP_ROW 4'h3

// Reset values
`define FPDP_RST_WORD 32'h00000000
`define FPDP_RST_OP 4'h0

`endif

/* File: hdl/fpdp_pkg.sv */
// Types shared by the flash program data path
package fpdp_pkg;

    // Whole register state of the top module
    typedef struct packed {
        logic [3:0] opSel;        // Operation select
        logic wrEnable;           // Write enable
        logic wrStart;            // Write in progress
        logic wrError;            // Sticky write error
        logic lvError;            // Sticky low-voltage error
        logic [31:0] target;      // Flash target address
        logic [31:0] dataLo;      // Low holding word
        logic [31:0] dataHi;      // High holding word
        logic [31:0] srcAddr;     // Row source address
        logic [31:0] rdata;       // Captured read data
        logic slvErr;             // Captured error answer
        logic startPulse;         // One-cycle operation start
        logic rowPulse;           // One-cycle row fetch request
    } fpdp_state_t;

endpackage : fpdp_pkg

/* File: hdl/fpdp_alias_merge.sv */
// Clear/set/invert alias merge for one 32-bit register
`timescale 1ns/1ps
`default_nettype none
`include "fpdp_consts.svh"

module fpdp_alias_merge
(
    input wire logic [31:0] oldVal,
    input wire logic [31:0] wrData,
    input wire logic [31:0] laneMask,
    input wire logic [1:0] aliasKind,
    output logic [31:0] newVal
);

    // Ones written through an alias act only on enabled byte lanes
    logic [31:0] ones;

    // Merge the written value with the old one
    always_comb
    begin
        ones = wrData & laneMask;
        case (aliasKind)
            `FPDP_ALIAS_CLR: newVal = oldVal & ~ones;
            `FPDP_ALIAS_SET: newVal = oldVal | ones;
            `FPDP_ALIAS_INV: newVal = oldVal ^ ones;
            default: newVal = (oldVal & ~laneMask) | ones;
        endcase
    end

endmodule : fpdp_alias_merge

`default_nettype wire

/* File: verif/fpdp_props.sv */
// Port checks of the flash program data path
`timescale 1ns/1ps
`default_nettype none
`include "fpdp_consts.svh"
module fpdp_props
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [3:0] flashOp,
    input wire logic flashStart,
    input wire logic [63:0] flashProgramData,
    input wire logic [31:0] rowSourceAddr,
    input wire logic rowFetch
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Full-word write at the completing access edge
    logic wrAll;
    assign wrAll = psel && penable && pwrite && pstrb == 4'hF;
    property p_lo; wrAll && paddr == `FPDP_OFF_DATA_LO |=> flashProgramData[31:0] == $past(pwdata); endproperty
    a_lo: assert property (p_lo) else $error("low word not staged");
    property p_hi; wrAll && paddr == `FPDP_OFF_DATA_HI |=> flashProgramData[63:32] == $past(pwdata); endproperty
    a_hi: assert property (p_hi) else $error("high word not staged");
    property p_op; wrAll && paddr == `FPDP_OFF_CTRL |=> flashOp == $past(pwdata[3:0]); endproperty
    a_op: assert property (p_op) else $error("operation field wrong");
    // Set alias ORs ones into the old value
    property p_set;
        wrAll && paddr == `FPDP_OFF_DATA_LO + 12'h8
        |=> flashProgramData[31:0] == ($past(flashProgramData[31:0]) | $past(pwdata));
    endproperty
    a_set: assert property (p_set) else $error("set alias wrong");
    property p_row; rowFetch |-> flashStart && flashOp == `FPDP_OP_ROW; endproperty
    a_row: assert property (p_row) else $error("row fetch without row start");
    property p_pulse; flashStart |=> !flashStart; endproperty
    a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
    property p_rst; $fell(sys_rst) |-> flashProgramData == 64'h0 && rowSourceAddr == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("staging not zero after reset");
    c_row: cover property (rowFetch);
    c_dw: cover property (flashStart && flashOp == `FPDP_OP_DWORD);
    c_set: cover property (wrAll && paddr == `FPDP_OFF_DATA_LO + 12'h8);
endmodule : fpdp_props
bind fpdp_top fpdp_props i_fpdp_props (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .flashOp, .flashStart, .flashProgramData, .rowSourceAddr, .rowFetch);
`default_nettype wire

/* File: verif/fpdp_flash_model.sv */
// Behavioural flash array answering program starts
`timescale 1ns/1ps
`default_nettype none
module fpdp_flash_model
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flashStart,
    input wire logic rowFetch,
    input wire logic [63:0] flashProgramData,
    input wire logic slow,
    input wire logic failNext,
    output logic flashDone,
    output logic flashError,
    output logic lowVoltError,
    output logic [7:0] nStarts,
    output logic [63:0] gotData,
    output logic gotRow
);
    logic [5:0] busyCnt; // Cycles left of the program
    // Supply stays healthy in this model
    assign lowVoltError = 1'b0;
    // Takes the word at start, answers after a short or long wait
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            {flashDone, flashError, nStarts, gotRow, busyCnt} <= '0;
        else
        begin
            flashDone <= busyCnt == 6'h01;
            flashError <= busyCnt == 6'h01 && failNext;
            if (flashStart)
            begin
                busyCnt <= slow ? 6'h14 : 6'h02;
                gotData <= flashProgramData;
                gotRow <= rowFetch;
                nStarts <= nStarts + 8'h01;
            end
            else if (busyCnt != 6'h00)
                busyCnt <= busyCnt - 6'h01;
        end
    end
endmodule : fpdp_flash_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the flash program data path
`timescale 1ns/1ps
`default_nettype none
`include "fpdp_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
    localparam logic [11:0] CT = `FPDP_OFF_CTRL;
    localparam logic [11:0] LO = `FPDP_OFF_DATA_LO;
    localparam logic [11:0] HI = `FPDP_OFF_DATA_HI;
    localparam logic [11:0] SR = `FPDP_OFF_SRCADDR;
    localparam logic [11:0] TG = `FPDP_OFF_TARGET;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, failNext = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, flashTargetAddr, rowSourceAddr, rd;
    logic [3:0] pstrb = 4'hF; // Lanes always whole words
    logic [3:0] flashOp;
    logic [63:0] flashProgramData, gotData;
    logic [7:0] nStarts;
    logic pready, pslverr, flashDone, flashError, lowVoltError, flashStart, rowFetch, gotRow, er;
    int n_errors = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    fpdp_top i_fpdp_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .flashDone, .flashError, .lowVoltError, .flashOp, .flashStart, .flashTargetAddr,
        .flashProgramData, .rowSourceAddr, .rowFetch);
    fpdp_flash_model i_fpdp_flash_model (.clk, .sys_rst, .flashStart, .rowFetch, .flashProgramData, .slow,
        .failNext, .flashDone, .flashError, .lowVoltError, .nStarts, .gotData, .gotRow);
    // One APB transfer; answer taken at the edge that sees pready high, only the watchdog ends a wait
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK("readData", e, rd)
    endtask : rdchk
    // Polls until the write bit drops, bounded
    task automatic wait_idle();
        int k = 0;
        rd = 32'h00008000;
        while (rd[15] !== 1'b0 && k < 60)
        begin
            apb(CT, 1'b0, 32'h0);
            k++;
        end
        `CHK("wrBit", 1'b0, rd[15])
    endtask : wait_idle
    task automatic t_regs();
        logic [11:0] regs [3] = '{LO, HI, SR};
        for (int i = 0; i < 3; i++)
        begin
            rdchk(regs[i], 32'h0);
            apb(regs[i], 1'b1, 32'hFFFFFFFF);
            rdchk(regs[i], 32'hFFFFFFFF);
        end
    endtask : t_regs
    task automatic t_alias();
        apb(LO, 1'b1, 32'h00FF00FF);
        apb(LO + 12'h8, 1'b1, 32'hF0000000);
        rdchk(LO, 32'hF0FF00FF);
        apb(LO + 12'h4, 1'b1, 32'h000F000F);
        rdchk(LO + 12'h4, 32'hF0F000F0);
        apb(LO + 12'hC, 1'b1, 32'hFFFF0000);
        rdchk(LO, 32'h0F0F00F0);
        apb(CT + 12'h8, 1'b1, 32'h00000005);
        rdchk(CT, 32'h00000005);
    endtask : t_alias
    task automatic t_dword();
        apb(LO, 1'b1, 32'h11223344);
        apb(HI, 1'b1, 32'h55667788);
        apb(TG, 1'b1, 32'h00001F00);
        `CHK("target", 32'h00001F00, flashTargetAddr)
        apb(CT, 1'b1, 32'h00008002);
        rdchk(CT, 32'h00000002);
        apb(CT, 1'b1, 32'h0000C002);
        wait_idle();
        `CHK("gotData", 64'h5566778811223344, gotData)
        `CHK("nStarts", 8'h01, nStarts)
        `CHK("gotRow", 1'b0, gotRow)
    endtask : t_dword
    task automatic t_row();
        slow <= 1'b1;
        failNext <= 1'b1;
        apb(SR, 1'b1, 32'h00000800);
        `CHK("srcAddr", 32'h00000800, rowSourceAddr)
        apb(CT, 1'b1, 32'h0000C003);
        wait_idle();
        `CHK("gotRow", 1'b1, gotRow)
        `CHK("wrErr", 1'b1, rd[13])
        apb(12'h390, 1'b0, 32'h0);
        `CHK("slvErr", 1'b1, er)
    endtask : t_row
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_alias();
        t_dword();
        t_row();
        tally_and_finish();
    end
    // Cuts a hang short, well beyond the 125 or so cycles needed
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
